/* rtl/adc_gate_params.svh */
// constants for the converter queue and input switch register block
`ifndef ADC_GATE_PARAMS_SVH
`define ADC_GATE_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_CH6_DEPTH 12'h0AC
`define OFS_SWITCH 12'h0B8
`define OFS_CH_SELECT 12'h0C0
`define OFS_QUEUE_DATA 12'h0C4
`define OFS_SEL_DEPTH 12'h0C8
`define OFS_INT_STATUS 12'h0CC
`define OFS_INT_MASK 12'h0D0
`define OFS_DMA_ENABLE 12'h0D4
`define OFS_GLOBAL_EN 12'h0D8
`define ADDR_W 12

// ==========================================================
// field layout
`define SWITCH_LSB 1
`define SWITCH_MSB 4
`define LEVEL_W 3
`define USER_CH 4
`define CH6_USER_IDX 2'h3
`define ALL_CH 8
`define SEL_LSB 3
`define SEL_MSB 4
`define SEL_VALID 32'h0000_0018
`define EVT_W 5
`define EVT_LANE 8
`define EVT_VALID 32'h1F1F_1F1F
`define RESULT_W 12
`define STAMP_W 17

// ==========================================================
// event encoding, per channel lane
`define EVT_DONE 5'h10
`define EVT_OVERFLOW 5'h08
`define EVT_UNDERFLOW 5'h04
`define EVT_EMPTY 5'h02
`define EVT_FULL 5'h01

// ==========================================================
// channel selection codes
`define CODE_USER0 32'h0000_0000
`define CODE_USER1 32'h0000_0008
`define CODE_USER2 32'h0000_0010
`define CODE_USER3 32'h0000_0018

// ==========================================================
// queue shape and reset values
`define QUEUE_DEPTH 4
`define QUEUE_PTR_W 2
`define LEVEL_FULL 3'h4
`define LEVEL_ONE 3'h1
`define LEVEL_THREE 3'h3
`define RESET_WORD 32'h0000_0000
`define RESET_SWITCH 4'h0

`endif

/* rtl/adc_gate_pkg.sv */
// types shared by the converter queue and switch block
package adc_gate_pkg;
  // ==========================================================
  // bus slave phase
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;

  typedef logic [31:0] word_type;
endpackage

/* rtl/sample_queue.sv */
// four-word sample queue with occupancy count
`timescale 1ns/10ps
`default_nettype none
`include "adc_gate_params.svh"

module sample_queue
  import adc_gate_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic push,
  input wire logic [31:0] push_data,
  // drain side
  input wire logic pop,
  output logic [31:0] head,
  // state
  output logic [`LEVEL_W-1:0] level,
  output logic full,
  output logic empty
);
  word_type store [`QUEUE_DEPTH];
  logic [`QUEUE_PTR_W-1:0] wr_ptr, next_wr_ptr;
  logic [`QUEUE_PTR_W-1:0] rd_ptr, next_rd_ptr;
  logic [`LEVEL_W-1:0] next_level;
  logic do_push, do_pop;

  // a push into a full queue is dropped unless a pop frees a slot
  always_comb begin
    full = (level == `LEVEL_FULL);
    empty = (level == `LEVEL_W'(0));
    do_pop = pop & ~empty;
    do_push = push & (~full | do_pop);
    head = empty ? `RESET_WORD : store[rd_ptr];
    next_wr_ptr = wr_ptr + `QUEUE_PTR_W'(do_push);
    next_rd_ptr = rd_ptr + `QUEUE_PTR_W'(do_pop);
    next_level = level + `LEVEL_W'(do_push) - `LEVEL_W'(do_pop);
  end

  // pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // storage has no reset; empty masks stale words
  always_ff @(posedge pclk) begin
    if (do_push) begin
      store[wr_ptr] <= push_data;
    end
  end
endmodule // sample_queue

`default_nettype wire

/* rtl/adc_channel_fifo_gate.sv */
// converter channel queues, input switches, events and APB registers
// ==========================================================
// What this block does
// - each queue holds four words; occupancy 0..4 reads in a 3-bit field
// - four read/write switch bits sit in bits 4 down to 1
// - switch bits reset to zero, so all inputs start isolated
// - bits 1..4 connect channels 0, 2, 4 and 6 to their inputs
// - eight converter channels, four exposed to the user
// - samples leave by processor reads or by per-channel DMA
// - event codes done 10, overflow 08, underflow 04, empty 02, full 01
// - user channels are selected by codes 0, 08, 10 and 18
// - queue word holds result in bits 13..2, stamp in bits 30..14
// - only enabled event sources drive the interrupt
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "adc_gate_params.svh"

module adc_channel_fifo_gate
  import adc_gate_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core, same clock
  input wire logic [`USER_CH-1:0] sample_strobe,
  input wire logic [`RESULT_W-1:0] sample_result,
  input wire logic [`STAMP_W-1:0] sample_stamp,
  output logic converter_enable,
  output logic [`USER_CH-1:0] input_switch_bits,
  // dma side
  output logic [`USER_CH-1:0] dma_req,
  input wire logic [`USER_CH-1:0] dma_ack,
  output logic [31:0] dma_data,
  // interrupt
  output logic irq
);
  // ==========================================================
  // state
  // every next_ value comes from the combinational blocks below
  bus_state_type bus_state, next_bus_state;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [`USER_CH-1:0] next_switch;
  logic [`SEL_MSB:`SEL_LSB] ch_select, next_ch_select;
  logic [`USER_CH-1:0] dma_enable, next_dma_enable;
  logic next_global_en;
  word_type int_status, next_int_status;
  word_type int_mask, next_int_mask;
  logic next_irq;
  logic [`USER_CH-1:0] next_dma_req;
  logic [31:0] next_dma_data;

  // ==========================================================
  // queue wiring
  // one lane per user channel; every array below is indexed by lane
  logic [31:0] sample_word;
  logic [`USER_CH-1:0] push, pop, pop_cpu, pop_dma;
  logic [`USER_CH-1:0] q_full, q_empty;
  logic [31:0] q_head [`USER_CH];
  logic [`LEVEL_W-1:0] q_level [`USER_CH];
  logic [`EVT_W-1:0] q_event [`USER_CH];
  word_type event_flat;
  logic bus_capture, bus_commit, addr_hit;
  logic [`QUEUE_PTR_W-1:0] sel_idx;

  // result in 13..2, stamp in 30..14, top and bottom bits zero
  // bit 31 and bits 1..0 are reserved and always read back zero
  assign sample_word = {1'b0, sample_stamp, sample_result, 2'b00};

  // codes step by eight, so bits 4..3 name the user channel
  // stray low bits of a code are dropped at the write
  assign sel_idx = ch_select;

  // bus phases: capture computes the answer, commit ends the transfer
  assign bus_capture = psel & penable & (bus_state == BUS_IDLE);
  assign bus_commit = psel & penable & pready;

  // ==========================================================
  // per-channel queues and their events
  // the core has eight channels; the four internal ones never reach
  // this block, so only the user lanes own a queue and a switch
  // lane c here is converter channel 2*c, the even-numbered inputs
  genvar c;
  generate
    for (c = 0; c < `USER_CH; c++) begin : g_ch
      // only a connected input with the converter on fills its queue
      assign push[c] = sample_strobe[c] & converter_enable & input_switch_bits[c];
      // read of the data window drains the selected queue
      assign pop_cpu[c] = bus_capture & ~pwrite & (paddr == `OFS_QUEUE_DATA)
                          & (sel_idx == `QUEUE_PTR_W'(c));
      assign pop_dma[c] = dma_ack[c] & dma_enable[c];
      assign pop[c] = pop_cpu[c] | pop_dma[c];

      sample_queue u_queue (
        .pclk(pclk),
        .presetn(presetn),
        .push(push[c]),
        .push_data(sample_word),
        .pop(pop[c]),
        .head(q_head[c]),
        .level(q_level[c]),
        .full(q_full[c]),
        .empty(q_empty[c])
      );

      // event sources in their fixed bit places
      // empty and full fire on the transition into that level only
      always_comb begin
        q_event[c] = '0;
        if (pop_dma[c] & ~q_empty[c]) begin
          q_event[c] = q_event[c] | `EVT_DONE;
        end
        if (push[c] & q_full[c] & ~pop[c]) begin
          q_event[c] = q_event[c] | `EVT_OVERFLOW;
        end
        if (pop[c] & q_empty[c]) begin
          q_event[c] = q_event[c] | `EVT_UNDERFLOW;
        end
        if (pop[c] & ~push[c] & (q_level[c] == `LEVEL_ONE)) begin
          q_event[c] = q_event[c] | `EVT_EMPTY;
        end
        if (push[c] & ~pop[c] & (q_level[c] == `LEVEL_THREE)) begin
          q_event[c] = q_event[c] | `EVT_FULL;
        end
      end

      assign event_flat[c*`EVT_LANE +: `EVT_LANE] = {3'h0, q_event[c]};
    end
  endgenerate

  // ==========================================================
  // address decode
  // a miss answers with an error and zero data rather than stalling,
  // so a wrong pointer in software cannot hang the bus
  always_comb begin
    case (paddr)
      `OFS_CH6_DEPTH, `OFS_SWITCH, `OFS_CH_SELECT, `OFS_QUEUE_DATA,
      `OFS_SEL_DEPTH, `OFS_INT_STATUS, `OFS_INT_MASK, `OFS_DMA_ENABLE,
      `OFS_GLOBAL_EN: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // bus slave: one wait state, answer registered
  // registering the answer costs a cycle per transfer but keeps every
  // output straight from a flop; a queue pop happens at the capture
  // edge, so the popped word is the one returned
  always_comb begin
    next_bus_state = bus_state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    case (bus_state)
      BUS_IDLE: begin
        if (psel & penable) begin
          next_bus_state = BUS_DONE;
          next_pready = 1'b1;
          next_pslverr = ~addr_hit;
          next_prdata = '0;
          if (!pwrite) begin
            case (paddr)
              // channel 6 is user channel three
              `OFS_CH6_DEPTH: next_prdata = {29'h0, q_level[`CH6_USER_IDX]};
              `OFS_SWITCH: next_prdata = {27'h0, input_switch_bits, 1'b0};
              `OFS_CH_SELECT: next_prdata = {27'h0, ch_select, 3'h0};
              `OFS_QUEUE_DATA: next_prdata = q_head[sel_idx];
              `OFS_SEL_DEPTH: next_prdata = {29'h0, q_level[sel_idx]};
              `OFS_INT_STATUS: next_prdata = int_status;
              `OFS_INT_MASK: next_prdata = int_mask;
              `OFS_DMA_ENABLE: next_prdata = {28'h0, dma_enable};
              `OFS_GLOBAL_EN: next_prdata = {31'h0, converter_enable};
              default: next_prdata = '0;
            endcase
          end
        end
      end
      BUS_DONE: begin
        // master drops penable after the ready edge
        next_bus_state = BUS_IDLE;
      end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  // answer registers; prdata keeps its last word until the next transfer, which loads zero on a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RESET_WORD;
    end else begin
      bus_state <= next_bus_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // control registers, written at the completing edge only
  // a cleared switch bit isolates its input even while the core
  // keeps strobing that channel, so nothing reaches the queue
  always_comb begin
    next_switch = input_switch_bits;
    next_ch_select = ch_select;
    next_dma_enable = dma_enable;
    next_global_en = converter_enable;
    next_int_mask = int_mask;
    if (bus_commit & pwrite) begin
      case (paddr)
        // reserved bits 31..5 and 0 are dropped
        `OFS_SWITCH: next_switch = pwdata[`SWITCH_MSB:`SWITCH_LSB];
        `OFS_CH_SELECT: next_ch_select = pwdata[`SEL_MSB:`SEL_LSB];
        `OFS_DMA_ENABLE: next_dma_enable = pwdata[`USER_CH-1:0];
        `OFS_GLOBAL_EN: next_global_en = pwdata[0];
        `OFS_INT_MASK: next_int_mask = pwdata & `EVT_VALID;
        default: next_switch = input_switch_bits;
      endcase
    end
  end

  // every input starts isolated and the converter starts off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_switch_bits <= `RESET_SWITCH;
      ch_select <= '0;
      dma_enable <= '0;
      converter_enable <= 1'b0;
      int_mask <= `RESET_WORD;
    end else begin
      input_switch_bits <= next_switch;
      ch_select <= next_ch_select;
      dma_enable <= next_dma_enable;
      converter_enable <= next_global_en;
      int_mask <= next_int_mask;
    end
  end

  // ==========================================================
  // sticky events: write one to clear, a new event wins over the clear
  // otherwise a clear could hide an event landing in the same cycle;
  // software then sees it on its next status read
  always_comb begin
    next_int_status = int_status;
    if (bus_commit & pwrite & (paddr == `OFS_INT_STATUS)) begin
      next_int_status = next_int_status & ~pwdata;
    end
    next_int_status = (next_int_status | event_flat) & `EVT_VALID;
    // masked sources never reach the line
    next_irq = |(next_int_status & int_mask);
  end

  // irq follows the next status, so it rises with the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= `RESET_WORD;
      irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // dma: request while a word waits; lowest acked channel supplies data
  // limitation: two acks in one cycle pop both queues but hand over
  // only the lowest word; the engine must ack one channel at a time
  always_comb begin
    next_dma_data = dma_data;
    for (int i = `USER_CH - 1; i >= 0; i--) begin
      if (pop_dma[i]) begin
        next_dma_data = q_head[i];
      end
    end
    // drop the request while a pop is in flight to avoid a double take
    next_dma_req = dma_enable & ~q_empty & ~pop;
  end

  // request and data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= '0;
      dma_data <= `RESET_WORD;
    end else begin
      dma_req <= next_dma_req;
      dma_data <= next_dma_data;
    end
  end
endmodule // adc_channel_fifo_gate

`default_nettype wire

/* verification/adc_gate_checker.sv */
// concurrent checks on the queue and switch block ports
`timescale 1ns/10ps
`default_nettype none
`include "adc_gate_params.svh"

// ==========================================================
// checker
module adc_gate_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter, dma, interrupt
  input wire logic converter_enable,
  input wire logic [`USER_CH-1:0] input_switch_bits,
  input wire logic [`USER_CH-1:0] dma_req,
  input wire logic [`USER_CH-1:0] dma_ack,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completing transfers, as the master samples them
  logic rd;
  logic wr;
  assign rd = psel && penable && pready && !pwrite;
  assign wr = psel && penable && pready && pwrite;
  wait_state_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  reset_quiet_a: assert property ($rose(presetn) |->
    !input_switch_bits && !irq && !dma_req) else $error("outputs not quiet after reset");
  switch_write_a: assert property (wr && paddr == `OFS_SWITCH |=>
    input_switch_bits == $past(pwdata[`SWITCH_MSB:`SWITCH_LSB])) else $error("switch write lost");
  switch_read_a: assert property (rd && paddr == `OFS_SWITCH |->
    prdata == {27'h0, input_switch_bits, 1'b0}) else $error("switch readback wrong");
  depth_range_a: assert property (rd && paddr == `OFS_CH6_DEPTH |-> prdata <= 32'h4)
    else $error("depth out of range");
  unmapped_zero_a: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  select_code_a: assert property (rd && paddr == `OFS_CH_SELECT |->
    (prdata & ~`SEL_VALID) == 32'h0) else $error("select code off grid");
  dma_drop_a: assert property ((dma_ack & dma_req) != 4'h0 |=>
    (dma_req & $past(dma_ack)) == 4'h0) else $error("request held after ack");
  enable_write_a: assert property (wr && paddr == `OFS_GLOBAL_EN |=>
    converter_enable == $past(pwdata[0])) else $error("global enable write lost");
  cover property (rd && paddr == `OFS_QUEUE_DATA);
  cover property ($rose(irq));
  cover property (dma_ack != 4'h0);
endmodule // adc_gate_checker

bind adc_channel_fifo_gate adc_gate_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .converter_enable, .input_switch_bits,
  .dma_req, .dma_ack, .irq);
`default_nettype wire

/* verification/converter_model.sv */
// behavioural converter core and dma engine beside the block
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// far side model
module converter_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic [3:0] fire,
  input wire logic [11:0] res_in,
  input wire logic [16:0] stamp_in,
  input wire logic slow,
  // block side
  output logic [3:0] sample_strobe,
  output logic [11:0] sample_result,
  output logic [16:0] sample_stamp,
  input wire logic [3:0] dma_req,
  output logic [3:0] dma_ack
);
  logic [3:0] hold;
  // contents valid only with the strobe; inverted otherwise so stale data cannot pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_strobe <= 4'h0;
      sample_result <= 12'h0;
      sample_stamp <= 17'h0;
    end else begin
      sample_strobe <= fire;
      sample_result <= (fire != 4'h0) ? res_in : ~sample_result;
      sample_stamp <= (fire != 4'h0) ? stamp_in : ~sample_stamp;
    end
  end
  // ack the lowest request, then back off so the request may fall and return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack <= 4'h0;
      hold <= 4'h0;
    end else begin
      dma_ack <= 4'h0;
      if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else if (dma_req != 4'h0) begin
        dma_ack <= dma_req & (~dma_req + 4'h1);
        hold <= slow ? 4'h9 : 4'h3;
      end
    end
  end
endmodule // converter_model
`default_nettype wire

/* verification/tb_adc_channel_fifo_gate.sv */
// self-checking bench for the queue and switch block
`timescale 1ns/10ps
`default_nettype none
`include "adc_gate_params.svh"

// ==========================================================
// bench top
module tb_adc_channel_fifo_gate;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, converter_enable, irq, slow;
  logic [11:0] paddr, res_in, sample_result;
  logic [31:0] pwdata, prdata, dma_data, r;
  logic [16:0] stamp_in, sample_stamp;
  logic [3:0] fire, sample_strobe, input_switch_bits, dma_req, dma_ack, ack_d, sw;
  int miscompares, comparisons;
  int cnt[4];
  logic [32:0] exp_q[$];
  logic [31:0] words[4][$];
  adc_channel_fifo_gate dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sample_strobe, .sample_result, .sample_stamp,
    .converter_enable, .input_switch_bits, .dma_req, .dma_ack, .dma_data, .irq);
  converter_model model_u (.pclk, .presetn, .fire, .res_in, .stamp_in, .slow,
    .sample_strobe, .sample_result, .sample_stamp, .dma_req, .dma_ack);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task check(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one compare task per kind of result
  task check_read(input logic [32:0] e, input logic [32:0] g);
    check("prdata", e, g);
  endtask
  task check_dma(input string nm, input logic [32:0] e, input logic [32:0] g);
    check(nm, e, g);
  endtask
  task check_irq(input logic e);
    check("irq", {32'h0, e}, {32'h0, irq});
  endtask
  task end_of_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // apb master: setup, access, hold until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // samples land only where the switch is closed; a full queue drops them
  task push(input logic [3:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      r = $urandom;
      fire <= m;
      res_in <= r[11:0];
      stamp_in <= r[28:12];
      for (int c = 0; c < 4; c++) if (m[c] && sw[c] && cnt[c] < 4) begin
        words[c].push_back({1'b0, r[28:12], r[11:0], 2'b00});
        cnt[c]++;
      end
    end
    @(posedge pclk);
    fire <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  task drain(input int c);
    apb(1'b1, `OFS_CH_SELECT, 32'(c * 8));
    rd(`OFS_QUEUE_DATA, {1'b0, words[c].pop_front()});
    cnt[c]--;
  endtask
  // ==========================================================
  // monitors: oldest note against each completed read and each channel-one dma word
  always @(posedge pclk) if (psel && penable && pready && !pwrite)
    check_read(exp_q.pop_front(), {pslverr, prdata});
  always @(posedge pclk) begin
    ack_d <= dma_ack;
    if (ack_d[1] === 1'b1) begin
      check_dma("dma_data", {1'b0, words[1].pop_front()}, {1'b0, dma_data});
      cnt[1]--;
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fire, res_in, stamp_in, slow} = '0;
    sw = 4'h0;
    r = $urandom(32'h9585);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CH6_DEPTH, 33'h0);
    rd(`OFS_SWITCH, 33'h0);
    rd(12'h0FC, 33'h1_0000_0000);
    repeat (4) begin
      r = $urandom;
      apb(1'b1, `OFS_SWITCH, r);
      rd(`OFS_SWITCH, {1'b0, r & 32'h1E});
    end
    // one switch at a time; every channel strobes, only the connected one fills
    for (int c = 0; c < 4; c++) begin
      sw = 4'h1 << c;
      apb(1'b1, `OFS_SWITCH, {27'h0, sw, 1'b0});
      apb(1'b1, `OFS_GLOBAL_EN, 32'h1);
      push(4'hF, 1);
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, `OFS_CH_SELECT, 32'(k * 8));
        rd(`OFS_CH_SELECT, 33'(k * 8));
        rd(`OFS_SEL_DEPTH, 33'(k == c));
      end
      rd(`OFS_CH6_DEPTH, 33'(c == 3));
      drain(c);
    end
    rd(`OFS_INT_STATUS, 33'h0202_0202);
    apb(1'b1, `OFS_INT_STATUS, 32'hFFFF_FFFF);
    rd(`OFS_INT_STATUS, 33'h0);
    // overflow, interrupt masking, underflow on an empty queue
    sw = 4'h1;
    apb(1'b1, `OFS_SWITCH, 32'h2);
    push(4'h1, 5);
    apb(1'b1, `OFS_CH_SELECT, `CODE_USER0);
    rd(`OFS_SEL_DEPTH, 33'h4);
    rd(`OFS_INT_STATUS, 33'h9);
    check_irq(1'b0);
    apb(1'b1, `OFS_INT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check_irq(1'b1);
    repeat (4) drain(0);
    rd(`OFS_QUEUE_DATA, 33'h0);
    rd(`OFS_INT_STATUS, 33'hF);
    apb(1'b1, `OFS_INT_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    check_irq(1'b0);
    // dma drain of channel one with a slow engine
    apb(1'b1, `OFS_INT_STATUS, 32'hFFFF_FFFF);
    sw = 4'h2;
    slow <= 1'b1;
    apb(1'b1, `OFS_SWITCH, 32'h4);
    apb(1'b1, `OFS_DMA_ENABLE, 32'h2);
    push(4'h2, 3);
    repeat (60) @(posedge pclk);
    check_dma("dma_left", 33'h0, 33'(words[1].size()));
    rd(`OFS_INT_STATUS, 33'h1200);
    // global enable off: a strobe on a connected input must not fill
    apb(1'b1, `OFS_GLOBAL_EN, 32'h0);
    sw = 4'h0;
    push(4'h2, 1);
    apb(1'b1, `OFS_CH_SELECT, `CODE_USER1);
    rd(`OFS_SEL_DEPTH, 33'h0);
    rd(`OFS_GLOBAL_EN, 33'h0);
    end_of_test;
  end
endmodule // tb_adc_channel_fifo_gate
`default_nettype wire
